// [dv/hss_slave_model.sv]
// bus partner: a slave that watches for start conditions, shifts in bits and
// may acknowledge the ninth clock; it can also play a master holding data low
// assumes open drain lines with pullups, levels resolved in the testbench
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// slave and competing master model
// ----------------------------------------
module hss_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic ack_en,
   input wire logic hold_busy,
   output logic sda_pull,
   output logic [7:0] byte_seen,
   output logic [7:0] n_start
);
   logic [3:0] bit_cnt; // clocks since the last start
   logic ack_pull; // pulls data during the ninth clock
   initial begin
      bit_cnt = 4'h0;
      ack_pull = 1'b0;
      byte_seen = 8'h00;
      n_start = 8'h00;
   end
   // a released line goes to the pullup level, so only pulls are modelled
   assign sda_pull = ack_pull | hold_busy;
   // data falling while clock is high marks a start or repeated start
   always @(negedge sda) begin
      if (scl === 1'b1 && !hold_busy) begin
         n_start <= n_start + 8'h01;
         bit_cnt <= 4'h0;
         ack_pull <= 1'b0;
      end
   end
   // shift in msb first on clock rise; count saturates to avoid wrap
   always @(posedge scl) begin
      if (bit_cnt < 4'h8) begin
         byte_seen <= {byte_seen[6:0], sda};
      end
      if (bit_cnt < 4'hF) begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end
   // acknowledge only after the eighth bit, released at the next clock fall
   always @(negedge scl) begin
      ack_pull <= ack_en && (bit_cnt == 4'h8);
   end
endmodule
`default_nettype wire

// [dv/hss_tb.sv]
// self-checking bench for the preamble, fast rate and start executor
// assumes the slave model beside it and a shortened bus-free timeout
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import hss_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam int TMO = 2000; // short timeout keeps the run brief
   logic clk_sys, rstn, cmd_valid, txn_end, script_clear;
   hss_op_t cmd_op;
   logic [15:0] cmd_arg;
   logic cmd_ready, done, scl_o, scl_oe, sda_o, sda_oe;
   hss_res_t result;
   logic ack_en, hold_busy, sda_pull, mon_oe, oe_seen;
   logic [7:0] byte_seen, n_start, n0;
   logic scl_w, sda_w; // resolved wire levels
   int n_fail, tests_run, cyc;
   assign scl_w = !scl_oe;
   assign sda_w = !(sda_oe || sda_pull);
   hss_core #(.TIMEOUT_CYC(TMO)) i_hss_core (.clk_sys(clk_sys), .rstn(rstn),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
      .done(done), .result(result), .txn_end(txn_end), .script_clear(script_clear),
      .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe));
   hss_slave_model i_hss_slave_model (.scl(scl_w), .sda(sda_w), .ack_en(ack_en),
      .hold_busy(hold_busy), .sda_pull(sda_pull), .byte_seen(byte_seen), .n_start(n_start));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // flags any pin drive while the monitor window is open
   always @(posedge clk_sys) begin
      if (mon_oe && (scl_oe === 1'b1 || sda_oe === 1'b1)) begin
         oe_seen <= 1'b1;
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic final_report();
      if (n_fail == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one command: held until taken, then waits for done and judges result
   task automatic run_cmd(input hss_op_t op, input logic [15:0] arg, input hss_res_t exp);
      int i;
      i = 0;
      cyc = 0;
      @(posedge clk_sys);
      cmd_op <= op;
      cmd_arg <= arg;
      cmd_valid <= 1'b1;
      do begin
         @(posedge clk_sys);
         i++;
      end while (cmd_ready !== 1'b1 && i < 100);
      cmd_valid <= 1'b0;
      do begin
         @(posedge clk_sys);
         cyc++;
      end while (done !== 1'b1 && cyc < 40000);
      if (i >= 100 || cyc >= 40000) begin
         n_fail++;
         final_report();
      end
      check({13'h0000, result}, {13'h0000, exp});
   endtask
   task automatic clear_halt();
      @(posedge clk_sys);
      script_clear <= 1'b1;
      @(posedge clk_sys);
      script_clear <= 1'b0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // fast-only commands refused and halting while fast mode is off
   task automatic t_fast_off();
      run_cmd(HSS_OP_RATE, 16'h0D48, HSS_RES_ERR_NOFAST);
      repeat (3) @(posedge clk_sys);
      check({15'h0000, cmd_ready}, 16'h0000);
      clear_halt();
      run_cmd(HSS_OP_PREAMBLE, 16'h0001, HSS_RES_ERR_NOFAST);
      clear_halt();
   endtask
   // rate table: exact, above top, between, bottom, below all
   task automatic t_rates();
      logic [15:0] req [5];
      hss_res_t exp [5];
      req = '{16'h0D48, 16'h1388, 16'h0898, 16'h03E8, 16'h03E7};
      exp = '{HSS_RES_OK, HSS_RES_WARN_RATE, HSS_RES_WARN_RATE, HSS_RES_OK, HSS_RES_ERR_RATE};
      run_cmd(HSS_OP_SWITCH, 16'h0001, HSS_RES_OK);
      for (int k = 0; k < 5; k++) begin
         run_cmd(HSS_OP_RATE, req[k], exp[k]);
      end
      clear_halt();
      run_cmd(HSS_OP_SWITCH, 16'h0001, HSS_RES_OK);
      run_cmd(HSS_OP_RATE, 16'h06A4, HSS_RES_OK);
   endtask
   // another master keeps data low: no drive, error after the timeout
   task automatic t_busy();
      hold_busy <= 1'b1;
      oe_seen <= 1'b0;
      mon_oe <= 1'b1;
      // let the held-low data pass the pin synchronisers before asking
      repeat (4) @(posedge clk_sys);
      run_cmd(HSS_OP_START, 16'h0000, HSS_RES_ERR_TIMEOUT);
      mon_oe <= 1'b0;
      check({15'h0000, oe_seen}, 16'h0000);
      check({15'h0000, cyc >= TMO}, 16'h0001);
      hold_busy <= 1'b0;
      clear_halt();
   endtask
   // start on a free bus after the free time, then preamble nacked
   task automatic t_start_pre();
      n0 = n_start;
      run_cmd(HSS_OP_START, 16'h0000, HSS_RES_OK);
      check({8'h00, n_start}, {8'h00, n0 + 8'h01});
      check({15'h0000, cyc >= 1175}, 16'h0001);
      ack_en <= 1'b0;
      run_cmd(HSS_OP_PREAMBLE, 16'hFFFD, HSS_RES_OK);
      check({8'h00, byte_seen}, 16'h000D);
      check({8'h00, n_start}, {8'h00, n0 + 8'h01});
      check({15'h0000, cyc >= 22500}, 16'h0001);
   endtask
   // restart inside the transaction, then an acknowledged preamble halts
   task automatic t_restart_ack();
      n0 = n_start;
      run_cmd(HSS_OP_START, 16'h0000, HSS_RES_OK);
      check({8'h00, n_start}, {8'h00, n0 + 8'h01});
      ack_en <= 1'b1;
      run_cmd(HSS_OP_PREAMBLE, 16'h0002, HSS_RES_ERR_ACK);
      check({8'h00, byte_seen}, 16'h000A);
      check({15'h0000, cyc < 2000}, 16'h0001);
      repeat (3) @(posedge clk_sys);
      check({15'h0000, cmd_ready}, 16'h0000);
      ack_en <= 1'b0;
      @(posedge clk_sys);
      txn_end <= 1'b1;
      @(posedge clk_sys);
      txn_end <= 1'b0;
      clear_halt();
      run_cmd(HSS_OP_SWITCH, 16'h0000, HSS_RES_OK);
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = HSS_OP_SWITCH;
      cmd_arg = 16'h0000;
      txn_end = 1'b0;
      script_clear = 1'b0;
      ack_en = 1'b0;
      hold_busy = 1'b0;
      mon_oe = 1'b0;
      oe_seen = 1'b0;
      n_fail = 0;
      tests_run = 0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      t_fast_off();
      t_rates();
      t_busy();
      t_start_pre();
      t_restart_ack();
      final_report();
   end
   initial begin
      repeat (99000) @(posedge clk_sys);
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire

// [logic/hss_core.sv]
// bus master executing switch, preamble, fast rate and start commands
// assumes pins are open drain with pullups outside; one clock domain
//
// How it works
// - preamble relies on an earlier start
// - preamble byte is 00001 plus code bits
// - ninth clock releases data and samples acknowledge
// - acknowledge on preamble halts with error
// - rate command picks from fixed rate set
// - unsupported rate rounds down with warning
// - rate below all supported gives error
// - start waits for a free bus
// - no free bus in one second: error
// - start pulls data low, clock high
// - start inside transaction is repeated start
// - preamble and rate need fast mode switched on
`include "hss_map.svh"
`timescale 1ns/10ps
`default_nettype none
module hss_core #(
   parameter int TIMEOUT_CYC = `HSS_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire hss_pkg::hss_op_t cmd_op,
   input wire logic [15:0] cmd_arg,
   output logic cmd_ready,
   output logic done,
   output hss_pkg::hss_res_t result,
   input wire logic txn_end,
   input wire logic script_clear,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   import hss_pkg::*;

   // ----------------------------------------
   // constants at the widths they meet
   // ----------------------------------------
   localparam logic [10:0] STD_HALF = 11'(`HSS_HALF(`HSS_STD_KHZ));
   localparam logic [10:0] BUF_CYC = 11'(`HSS_BUF_CYC);
   localparam logic [27:0] TO_LAST = 28'(TIMEOUT_CYC - 1);

   // round a request down to a supported rate: {found, exact, index}
   function automatic logic [3:0] hss_pick(input logic [15:0] khz);
      if (khz >= 16'(`HSS_RATE0_KHZ)) begin
         hss_pick = {1'b1, khz == 16'(`HSS_RATE0_KHZ), 2'h0};
      end else if (khz >= 16'(`HSS_RATE1_KHZ)) begin
         hss_pick = {1'b1, khz == 16'(`HSS_RATE1_KHZ), 2'h1};
      end else if (khz >= 16'(`HSS_RATE2_KHZ)) begin
         hss_pick = {1'b1, khz == 16'(`HSS_RATE2_KHZ), 2'h2};
      end else begin
         hss_pick = 4'h0;
      end
   endfunction

   // half period for each supported rate
   function automatic logic [10:0] hss_half_of(input logic [1:0] idx);
      unique case (idx)
         2'h0: hss_half_of = 11'(`HSS_HALF(`HSS_RATE0_KHZ));
         2'h1: hss_half_of = 11'(`HSS_HALF(`HSS_RATE1_KHZ));
         default: hss_half_of = 11'(`HSS_HALF(`HSS_RATE2_KHZ));
      endcase
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   hss_state_t state_reg, state_next; // sequencer
   logic [27:0] cnt_reg, cnt_next; // phase / timeout counter
   logic [10:0] idle_reg, idle_next; // cycles both lines seen high
   logic [3:0] bit_reg, bit_next; // bit slot, 8 is acknowledge
   logic [7:0] shift_reg, shift_next; // preamble byte, msb first
   logic in_txn_reg, in_txn_next; // own start issued, no stop yet
   logic fast_en_reg, fast_en_next; // fast mode switched on
   logic armed_reg, armed_next; // preamble refused, restart pending
   logic use_fast_reg, use_fast_next; // clocking at the fast rate
   logic [10:0] fast_half_reg, fast_half_next; // chosen fast half period
   logic halted_reg, halted_next; // script stopped on an error
   logic ready_reg, ready_next;
   logic done_reg, done_next;
   hss_res_t res_reg, res_next;
   logic scl_oe_reg, scl_oe_next;
   logic sda_oe_reg, sda_oe_next;
   logic scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg; // pin synchronisers
   logic [10:0] half; // current half period
   logic half_end; // last cycle of a phase
   logic bus_free; // idle long enough to claim the bus
   logic take; // command accepted this cycle
   logic [3:0] pick;

   assign half = use_fast_reg ? fast_half_reg : STD_HALF;
   assign half_end = cnt_reg == {17'h0, half - 11'h001};
   assign bus_free = idle_reg == BUF_CYC;
   assign take = cmd_valid && ready_reg;
   assign pick = hss_pick(cmd_arg);

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg + 28'h1;
      // a bus idle counter; any low level restarts it
      idle_next = (scl_s2_reg && sda_s2_reg) ?
                  (bus_free ? idle_reg : idle_reg + 11'h001) : 11'h000;
      bit_next = bit_reg;
      shift_next = shift_reg;
      in_txn_next = in_txn_reg;
      fast_en_next = fast_en_reg;
      armed_next = armed_reg;
      use_fast_next = use_fast_reg;
      fast_half_next = fast_half_reg;
      halted_next = halted_reg && !script_clear;
      done_next = 1'b0;
      res_next = res_reg;
      scl_oe_next = scl_oe_reg;
      sda_oe_next = sda_oe_reg;
      // the stop logic elsewhere ends the transaction and the fast phase
      if (txn_end) begin
         in_txn_next = 1'b0;
         armed_next = 1'b0;
         use_fast_next = 1'b0;
      end
      unique case (state_reg)
         HSS_IDLE: begin
            cnt_next = 28'h0;
            if (take) begin
               unique case (cmd_op)
                  // fast mode on or off; off also drops a pending switch
                  HSS_OP_SWITCH: begin
                     fast_en_next = cmd_arg[`HSS_ARG_EN_BIT];
                     if (!cmd_arg[`HSS_ARG_EN_BIT]) begin
                        armed_next = 1'b0;
                        use_fast_next = 1'b0;
                     end
                     done_next = 1'b1;
                     res_next = HSS_RES_OK;
                  end
                  HSS_OP_PREAMBLE: begin
                     if (!fast_en_reg) begin
                        done_next = 1'b1;
                        res_next = HSS_RES_ERR_NOFAST;
                        halted_next = 1'b1;
                     end else begin
                        // no start of its own: clock already low from one
                        shift_next = {`HSS_PREFIX, cmd_arg[`HSS_ARG_CODE_MSB:0]};
                        bit_next = 4'h0;
                        scl_oe_next = 1'b1;
                        state_next = HSS_BIT_LO;
                     end
                  end
                  HSS_OP_RATE: begin
                     done_next = 1'b1;
                     if (!fast_en_reg) begin
                        res_next = HSS_RES_ERR_NOFAST;
                        halted_next = 1'b1;
                     end else if (!pick[3]) begin
                        res_next = HSS_RES_ERR_RATE;
                        halted_next = 1'b1;
                     end else begin
                        fast_half_next = hss_half_of(pick[1:0]);
                        res_next = pick[2] ? HSS_RES_OK : HSS_RES_WARN_RATE;
                     end
                  end
                  HSS_OP_START: begin
                     // inside a transaction the start becomes a restart
                     state_next = in_txn_reg ? HSS_RS_LO : HSS_WAIT_FREE;
                  end
               endcase
            end
         end
         HSS_WAIT_FREE: begin
            if (bus_free) begin
               sda_oe_next = 1'b1;
               cnt_next = 28'h0;
               state_next = HSS_ST_HOLD;
            end else if (cnt_reg == TO_LAST) begin
               done_next = 1'b1;
               res_next = HSS_RES_ERR_TIMEOUT;
               halted_next = 1'b1;
               state_next = HSS_IDLE;
            end
         end
         // restart: data released while clock low, then clock released
         HSS_RS_LO: begin
            scl_oe_next = 1'b1;
            sda_oe_next = 1'b0;
            if (half_end) begin
               scl_oe_next = 1'b0;
               cnt_next = 28'h0;
               state_next = HSS_RS_HI;
            end
         end
         HSS_RS_HI: begin
            // a slave stretching the clock holds the phase back
            if (!scl_s2_reg) begin
               cnt_next = 28'h0;
            end else if (half_end) begin
               sda_oe_next = 1'b1;
               cnt_next = 28'h0;
               state_next = HSS_ST_HOLD;
            end
         end
         // data low with clock high is the start itself
         HSS_ST_HOLD: begin
            if (half_end) begin
               scl_oe_next = 1'b1;
               cnt_next = 28'h0;
               in_txn_next = 1'b1;
               // after a refused preamble the restart moves to the fast rate
               if (armed_reg) begin
                  use_fast_next = 1'b1;
                  armed_next = 1'b0;
               end
               state_next = HSS_ST_LOW;
            end
         end
         HSS_ST_LOW: begin
            if (half_end) begin
               done_next = 1'b1;
               res_next = HSS_RES_OK;
               state_next = HSS_IDLE;
            end
         end
         HSS_BIT_LO: begin
            // data changes only while the clock is low
            if (cnt_reg == 28'h0) begin
               sda_oe_next = (bit_reg != `HSS_ACK_BIT) && !shift_reg[7];
            end
            if (half_end) begin
               scl_oe_next = 1'b0;
               cnt_next = 28'h0;
               state_next = HSS_BIT_HI;
            end
         end
         HSS_BIT_HI: begin
            if (!scl_s2_reg) begin
               cnt_next = 28'h0;
            end else if (half_end) begin
               scl_oe_next = 1'b1;
               cnt_next = 28'h0;
               if (bit_reg == `HSS_ACK_BIT) begin
                  done_next = 1'b1;
                  state_next = HSS_IDLE;
                  if (!sda_s2_reg) begin
                     res_next = HSS_RES_ERR_ACK;
                     halted_next = 1'b1;
                  end else begin
                     res_next = HSS_RES_OK;
                     armed_next = 1'b1;
                  end
               end else begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  bit_next = bit_reg + 4'h1;
                  state_next = HSS_BIT_LO;
               end
            end
         end
         default: begin
            state_next = HSS_IDLE;
         end
      endcase
      // an error clears the halt only by script_clear, never by itself
      ready_next = (state_next == HSS_IDLE) && !halted_next && !take;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg <= HSS_IDLE;
         cnt_reg <= 28'h0;
         idle_reg <= 11'h000;
         bit_reg <= 4'h0;
         shift_reg <= 8'h00;
         in_txn_reg <= 1'b0;
         fast_en_reg <= 1'b0;
         armed_reg <= 1'b0;
         use_fast_reg <= 1'b0;
         fast_half_reg <= 11'(`HSS_HALF(`HSS_RATE0_KHZ));
         halted_reg <= 1'b0;
         ready_reg <= 1'b0;
         done_reg <= 1'b0;
         res_reg <= HSS_RES_OK;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         idle_reg <= idle_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         in_txn_reg <= in_txn_next;
         fast_en_reg <= fast_en_next;
         armed_reg <= armed_next;
         use_fast_reg <= use_fast_next;
         fast_half_reg <= fast_half_next;
         halted_reg <= halted_next;
         ready_reg <= ready_next;
         done_reg <= done_next;
         res_reg <= res_next;
         scl_oe_reg <= scl_oe_next;
         sda_oe_reg <= sda_oe_next;
         scl_s1_reg <= scl_i;
         scl_s2_reg <= scl_s1_reg;
         sda_s1_reg <= sda_i;
         sda_s2_reg <= sda_s1_reg;
      end
   end

   // open drain: the driven level is always low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = scl_oe_reg;
   assign sda_oe = sda_oe_reg;
   assign cmd_ready = ready_reg;
   assign done = done_reg;
   assign result = res_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_ack_slot_end;
      state_reg == HSS_BIT_HI && bit_reg == `HSS_ACK_BIT && scl_s2_reg && half_end;
   endsequence
   sequence s_rate_cmd;
      take && cmd_op == HSS_OP_RATE && fast_en_reg;
   endsequence

   AST_PREFIX: assert property (state_reg == HSS_BIT_LO && bit_reg == 4'h0 |-> shift_reg[7:3] == 5'h01) else $error("preamble prefix wrong");
   AST_NO_OWN_START: assert property (state_reg == HSS_BIT_HI && !scl_oe_reg |-> $stable(sda_oe_reg)) else $error("data moved while clock high");
   AST_ACK_RELEASE: assert property (state_reg == HSS_BIT_HI && bit_reg == `HSS_ACK_BIT |-> !sda_oe_reg) else $error("data held in ack slot");
   AST_ACK_ERR: assert property (s_ack_slot_end ##0 !sda_s2_reg |=> done_reg && res_reg == HSS_RES_ERR_ACK ##1 !ready_reg) else $error("ack not reported");
   AST_RATE_LOW: assert property (s_rate_cmd ##0 cmd_arg < 16'(`HSS_RATE2_KHZ) |=> done_reg && res_reg == HSS_RES_ERR_RATE && $stable(fast_half_reg)) else $error("low rate accepted");
   AST_RATE_DOWN: assert property (s_rate_cmd ##0 cmd_arg == 16'h0898 |=> res_reg == HSS_RES_WARN_RATE && fast_half_reg == 11'(`HSS_HALF(`HSS_RATE1_KHZ))) else $error("rate not rounded down");
   AST_NOFAST: assert property (take && cmd_op != HSS_OP_SWITCH && cmd_op != HSS_OP_START && !fast_en_reg |=> done_reg && res_reg == HSS_RES_ERR_NOFAST) else $error("fast command without switch");
   AST_WAIT_FREE: assert property (state_reg == HSS_WAIT_FREE && !bus_free |=> !sda_oe_reg) else $error("start before bus free");
   AST_TIMEOUT: assert property (state_reg == HSS_WAIT_FREE && !bus_free && cnt_reg == TO_LAST |=> done_reg && res_reg == HSS_RES_ERR_TIMEOUT && !sda_oe_reg) else $error("timeout not reported");
   AST_START_COND: assert property (state_reg == HSS_ST_HOLD |-> sda_oe_reg && !scl_oe_reg) else $error("start shape wrong");
   AST_FAST_SWITCH: assert property ($rose(use_fast_reg) |-> $past(state_reg) == HSS_ST_HOLD && $past(armed_reg)) else $error("fast rate too early");
endmodule
`default_nettype wire

// [logic/hss_map.svh]
// constants for the preamble/rate/start command executor
// assumes a 250 MHz system clock; included by the design file
`ifndef HSS_MAP_SVH
`define HSS_MAP_SVH
// ----------------------------------------
// clock and times
// ----------------------------------------
`define HSS_CLK_HZ 250000000
`define HSS_CLK_NS 4
`define HSS_T_TIMEOUT_S 1
`define HSS_TIMEOUT_CYC (`HSS_T_TIMEOUT_S * `HSS_CLK_HZ)
`define HSS_T_BUF_NS 4700
`define HSS_BUF_CYC ((`HSS_T_BUF_NS + `HSS_CLK_NS - 1) / `HSS_CLK_NS)
// half bit period in cycles for a rate in kHz, rounded up (never too fast)
`define HSS_HALF(k) ((`HSS_CLK_HZ + 2000 * (k) - 1) / (2000 * (k)))
`define HSS_STD_KHZ 100
// ----------------------------------------
// supported fast rates in kHz, highest first
// ----------------------------------------
`define HSS_RATE0_KHZ 3400
`define HSS_RATE1_KHZ 1700
`define HSS_RATE2_KHZ 1000
// ----------------------------------------
// fields of the command argument
// ----------------------------------------
`define HSS_PREFIX 5'h01
`define HSS_ARG_CODE_MSB 2
`define HSS_ARG_EN_BIT 0
`define HSS_ACK_BIT 4'h8
`endif

// [logic/hss_pkg.sv]
// types shared by the command executor and its users
// assumes nothing beyond a SystemVerilog compiler
package hss_pkg;
   // command codes on the script port
   typedef enum logic [1:0] {
      HSS_OP_SWITCH = 2'h0,
      HSS_OP_PREAMBLE = 2'h1,
      HSS_OP_RATE = 2'h2,
      HSS_OP_START = 2'h3
   } hss_op_t;
   // outcome reported with each done pulse
   typedef enum logic [2:0] {
      HSS_RES_OK = 3'h0,
      HSS_RES_WARN_RATE = 3'h1,
      HSS_RES_ERR_ACK = 3'h2,
      HSS_RES_ERR_TIMEOUT = 3'h3,
      HSS_RES_ERR_RATE = 3'h4,
      HSS_RES_ERR_NOFAST = 3'h5
   } hss_res_t;
   // sequencer states
   typedef enum logic [3:0] {
      HSS_IDLE = 4'h0,
      HSS_WAIT_FREE = 4'h1,
      HSS_RS_LO = 4'h2,
      HSS_RS_HI = 4'h3,
      HSS_ST_HOLD = 4'h4,
      HSS_ST_LOW = 4'h5,
      HSS_BIT_LO = 4'h6,
      HSS_BIT_HI = 4'h7
   } hss_state_t;
endpackage
